// ==== rtl/lldc_params.svh ====
// Offsets, field positions, reset values and timing for the LED drive loop.
// Included by the package only; the LED drive loop top module sees its macros through that include.
`ifndef LLDC_PARAMS_SVH
`define LLDC_PARAMS_SVH

// ****************************************************
// Register indices (byte address is four times these)
// ****************************************************
`define LLDC_IDX_GAIN     12'h883
`define LLDC_IDX_CTRL     12'h886
`define LLDC_IDX_LOOP     12'h887
`define LLDC_IDX_INTR     12'h889
`define LLDC_IDX_READBACK 12'h88F

// ****************************************************
// Field positions
// ****************************************************
`define LLDC_MODE_BIT     7
`define LLDC_FAST_BIT     7
`define LLDC_GAIN_TOP     3
`define LLDC_ST_LOOP_BIT  6
`define LLDC_MK_LOOP_BIT  2

// ****************************************************
// Reset values
// ****************************************************
`define LLDC_CTRL_RST     8'h00
`define LLDC_LOOP_RST     8'h40
`define LLDC_GAIN_RST     4'h0
`define LLDC_MASK_RST     3'h0

// ****************************************************
// Analog codes: gain table, target and reference in mV
// ****************************************************
`define LLDC_GAIN_0       7'h04
`define LLDC_GAIN_1       7'h06
`define LLDC_GAIN_2       7'h08
`define LLDC_GAIN_3       7'h0C
`define LLDC_GAIN_4       7'h10
`define LLDC_GAIN_5       7'h18
`define LLDC_GAIN_6       7'h20
`define LLDC_GAIN_7       7'h30
`define LLDC_GAIN_MAX     7'h40
`define LLDC_TGT_BASE_MV  11'h1F4
`define LLDC_TGT_STEP_MV  11'h064
`define LLDC_FB_REF_0_MV  11'h47E
`define LLDC_FB_REF_1_MV  11'h4B0
`define LLDC_FB_REF_2_MV  11'h4E2
`define LLDC_FB_REF_3_MV  11'h514

// ****************************************************
// Timing: update periods in seconds and clock rate
// ****************************************************
`define LLDC_CLK_HZ       40000000
`define LLDC_SLOW_S       16
`define LLDC_FAST_S       1

`endif

// ==== rtl/lldc_pkg.sv ====
// Types shared by the LED drive loop block.
// Assumes the constants header sits beside it on the include path.
package lldc_pkg;
  `include "lldc_params.svh"

  // Regulation mode, one-hot
  typedef enum logic [1:0] {
    LLDC_OPEN   = 2'b01,
    LLDC_CLOSED = 2'b10
  } lldc_mode_e;

  // LED current code, 0.6 mA per step
  typedef logic [6:0] lldc_code_t;
endpackage

// ==== rtl/lldc_top.sv ====
// LED drive loop control: open/closed loop LED sink code, buffer gain
// decode, readback and loop alarm, reached over classic Wishbone.
// Assumes one 40 MHz clock, inputs synchronous to it, and an analog
// comparator telling whether the track amplitude is above target.
//
// Design decision made here: register access over Wishbone.

`timescale 1ns/1ps

module lldc_top
  import lldc_pkg::*;
#(
  parameter int unsigned SLOW_CYC = `LLDC_SLOW_S * `LLDC_CLK_HZ,
  parameter int unsigned FAST_CYC = `LLDC_FAST_S * `LLDC_CLK_HZ
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [13:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        amplitude_above,
  output logic      [6:0]  led_cathode_sink,
  output logic             sink_enable,
  output logic      [6:0]  buffer_gain_code,
  output logic      [10:0] amplitude_target_mv,
  output logic      [10:0] feedback_reference_mv,
  output logic             interrupt_out_n,
  output logic             interrupt_oe_n,
  output logic             irq
);

  // ****************************************************
  // Declarations
  // ****************************************************
  logic        ack_q,    ack_d;
  logic [31:0] rdat_q,   rdat_d;
  logic [7:0]  ctrl_q,   ctrl_d;
  logic [7:0]  loop_q,   loop_d;
  logic [3:0]  gain_q,   gain_d;
  logic [2:0]  mask_q,   mask_d;
  logic        stat_q,   stat_d;
  lldc_mode_e  mode_q,   mode_d;
  lldc_code_t  work_q,   work_d;
  logic [29:0] tmr_q,    tmr_d;
  logic [6:0]  bgain_q,  bgain_d;
  logic [10:0] tgt_q,    tgt_d;
  logic [10:0] fbref_q,  fbref_d;
  logic        sinken_q, sinken_d;
  logic [11:0] idx;
  logic        take;
  logic        wr;
  logic        rd_intr;
  logic        tick;
  logic        alarm;
  logic [29:0] period;
  lldc_code_t  max_code;
  lldc_code_t  entry_code;
  logic [9:0]  work_x8;
  logic [9:0]  max_x7;

  // ****************************************************
  // Wishbone slave
  // ****************************************************
  // One wait state; ack drops the cycle after it is given
  assign idx     = wb_adr_i[13:2];
  assign take    = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr      = take & wb_we_i & wb_sel_i[0];
  assign rd_intr = take & ~wb_we_i & (idx == `LLDC_IDX_INTR);

  // Read mux; unmapped addresses read zero and are still acked
  always_comb begin
    ack_d  = take;
    rdat_d = rdat_q;
    if (take & ~wb_we_i) begin
      rdat_d = 32'h0000_0000;
      unique case (idx)
        `LLDC_IDX_GAIN:     rdat_d[3:0] = gain_q;
        `LLDC_IDX_CTRL:     rdat_d[7:0] = ctrl_q;
        `LLDC_IDX_LOOP:     rdat_d[7:0] = loop_q;
        `LLDC_IDX_INTR: begin
          rdat_d[`LLDC_ST_LOOP_BIT] = stat_q;
          rdat_d[2:0]               = mask_q;
        end
        `LLDC_IDX_READBACK: rdat_d[7:0] = {ctrl_q[`LLDC_MODE_BIT],
                                           work_q};
        default:            rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ****************************************************
  // Software registers
  // ****************************************************
  // Byte lane 0 carries every field; upper lanes are ignored
  always_comb begin
    ctrl_d = ctrl_q;
    loop_d = loop_q;
    gain_d = gain_q;
    mask_d = mask_q;
    if (wr) begin
      unique case (idx)
        `LLDC_IDX_GAIN: gain_d = wb_dat_i[3:0];
        `LLDC_IDX_CTRL: ctrl_d = wb_dat_i[7:0];
        `LLDC_IDX_LOOP: loop_d = wb_dat_i[7:0];
        `LLDC_IDX_INTR: mask_d = wb_dat_i[2:0];
        default:        ctrl_d = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `LLDC_CTRL_RST;
      loop_q <= `LLDC_LOOP_RST;
      gain_q <= `LLDC_GAIN_RST;
      mask_q <= `LLDC_MASK_RST;
    end else begin
      ctrl_q <= ctrl_d;
      loop_q <= loop_d;
      gain_q <= gain_d;
      mask_q <= mask_d;
    end
  end

  // ****************************************************
  // Update timer
  // ****************************************************
  // Restarts on loop entry so the first step waits a full period
  assign period = loop_q[`LLDC_FAST_BIT] ? FAST_CYC[29:0]
                                         : SLOW_CYC[29:0];
  assign tick   = (mode_q == LLDC_CLOSED) && (tmr_q >= period - 30'h1);

  always_comb begin
    if ((mode_q != LLDC_CLOSED) || tick) begin
      tmr_d = 30'h0000_0000;
    end else begin
      tmr_d = tmr_q + 30'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tmr_q <= 30'h0000_0000;
    end else begin
      tmr_q <= tmr_d;
    end
  end

  // ****************************************************
  // Drive loop
  // ****************************************************
  assign max_code   = ctrl_q[6:0];
  assign max_x7     = {3'h0, max_code} * 10'h007;
  assign entry_code = max_x7[9:3];
  assign work_x8    = {work_q, 3'h0};

  // Mode follows control bit 7; working code tracks it
  always_comb begin
    mode_d = ctrl_q[`LLDC_MODE_BIT] ? LLDC_CLOSED : LLDC_OPEN;
    work_d = work_q;
    unique case (mode_q)
      LLDC_OPEN: begin
        if (ctrl_q[`LLDC_MODE_BIT]) begin
          work_d = entry_code;
        end else begin
          work_d = max_code;
        end
      end
      LLDC_CLOSED: begin
        if (tick) begin
          if (amplitude_above) begin
            if (work_q != 7'h00) begin
              work_d = work_q - 7'h01;
            end else begin
              work_d = 7'h00;
            end
          end else if (work_q != 7'h7F) begin
            work_d = work_q + 7'h01;
          end
        end
        // Also catches a lowered maximum written mid-loop
        if (work_d > max_code) begin
          work_d = max_code;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_q <= LLDC_OPEN;
      work_q <= 7'h00;
    end else begin
      mode_q <= mode_d;
      work_q <= work_d;
    end
  end

  assign led_cathode_sink = work_q;

  // ****************************************************
  // Analog settings decode
  // ****************************************************
  always_comb begin
    sinken_d = (ctrl_q != 8'h00);
    tgt_d    = `LLDC_TGT_BASE_MV
             + 11'(loop_q[2:0] * `LLDC_TGT_STEP_MV);
    if (gain_q[`LLDC_GAIN_TOP]) begin
      bgain_d = `LLDC_GAIN_MAX;
    end else begin
      unique case (gain_q[2:0])
        3'h0: bgain_d = `LLDC_GAIN_0;
        3'h1: bgain_d = `LLDC_GAIN_1;
        3'h2: bgain_d = `LLDC_GAIN_2;
        3'h3: bgain_d = `LLDC_GAIN_3;
        3'h4: bgain_d = `LLDC_GAIN_4;
        3'h5: bgain_d = `LLDC_GAIN_5;
        3'h6: bgain_d = `LLDC_GAIN_6;
        3'h7: bgain_d = `LLDC_GAIN_7;
      endcase
    end
    unique case (loop_q[6:5])
      2'h0: fbref_d = `LLDC_FB_REF_0_MV;
      2'h1: fbref_d = `LLDC_FB_REF_1_MV;
      2'h2: fbref_d = `LLDC_FB_REF_2_MV;
      2'h3: fbref_d = `LLDC_FB_REF_3_MV;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sinken_q <= 1'b0;
      tgt_q    <= `LLDC_TGT_BASE_MV;
      bgain_q  <= `LLDC_GAIN_0;
      fbref_q  <= `LLDC_FB_REF_0_MV;
    end else begin
      sinken_q <= sinken_d;
      tgt_q    <= tgt_d;
      bgain_q  <= bgain_d;
      fbref_q  <= fbref_d;
    end
  end

  assign sink_enable           = sinken_q;
  assign amplitude_target_mv   = tgt_q;
  assign buffer_gain_code      = bgain_q;
  assign feedback_reference_mv = fbref_q;

  // ****************************************************
  // Alarm and interrupt
  // ****************************************************
  // Out of regulation: working code above 7/8 of maximum
  assign alarm = (mode_q == LLDC_CLOSED) && (work_x8 > max_x7);

  // A new alarm beats the read that would clear it
  always_comb begin
    stat_d = alarm | (stat_q & ~rd_intr);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stat_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Pin follows the live condition; irq holds while status stays set
  assign interrupt_out_n = 1'b0;
  assign interrupt_oe_n  = ~(alarm & mask_q[`LLDC_MK_LOOP_BIT]);
  assign irq             = stat_q & mask_q[`LLDC_MK_LOOP_BIT];

  // ****************************************************
  // Assertions
  // ****************************************************
  ack_one_cycle_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (wb_cyc_i && wb_stb_i && !ack_q) |=> (ack_q ##1 !ack_q))
    else $error("ack not a single cycle after request");

  gain_top_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    gain_q[3] |=> (buffer_gain_code == 7'h40))
    else $error("gain top bit did not give 64");

  open_follow_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (mode_q == LLDC_OPEN && !ctrl_q[7])
      |=> (led_cathode_sink == $past(ctrl_q[6:0])))
    else $error("open loop sink differs from code");

  all_zero_off_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (ctrl_q == 8'h00) [*2] |-> (!sink_enable && led_cathode_sink == 7'h00))
    else $error("zero control did not turn sink off");

  loop_entry_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (mode_q == LLDC_OPEN && ctrl_q[7])
      |=> (work_q == 7'(($past(ctrl_q[6:0]) * 7) >> 3)))
    else $error("closed loop entry code wrong");

  max_clamp_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (mode_q == LLDC_CLOSED && ctrl_q[7]) |=> (work_q <= $past(ctrl_q[6:0])))
    else $error("closed loop exceeded maximum");

  step_down_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (tick && amplitude_above && work_q != 7'h00 && ctrl_q[7]
      && work_q <= ctrl_q[6:0]) |=> (work_q == $past(work_q) - 7'h01))
    else $error("step down missing");

  zero_floor_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (tick && amplitude_above && work_q == 7'h00 && ctrl_q[7])
      |=> (work_q == 7'h00))
    else $error("working code wrapped below zero");

  sticky_status_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (stat_q && !rd_intr) |=> stat_q)
    else $error("status bit dropped without read");

  alarm_set_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (mode_q == LLDC_CLOSED && {work_q, 3'h0} > 10'(ctrl_q[6:0] * 7))
      |=> stat_q)
    else $error("alarm did not set status");

  irq_release_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (mode_q == LLDC_OPEN) |-> interrupt_oe_n)
    else $error("interrupt pin driven without alarm");

endmodule

// ==== bench/lldc_amp_model.sv ====
// Far-side model: LED, track amplitude and its comparator.
// Assumes track amplitude grows linearly with the sink code.
`timescale 1ns/1ps

module lldc_amp_model #(
  parameter int MV_PER_STEP = 20
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [6:0]  led_cathode_sink,
  input  wire logic        sink_enable,
  input  wire logic [10:0] amplitude_target_mv,
  input  wire logic        stuck_high,
  output logic             amplitude_above
);
  int amp_mv;

  // Amplitude is zero with the sink off
  always_comb begin
    amp_mv = sink_enable ? int'(led_cathode_sink) * MV_PER_STEP : 0;
  end

  // Comparator answers a cycle late; stuck_high mimics a faulty path
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      amplitude_above <= 1'b0;
    end else begin
      amplitude_above <= stuck_high || amp_mv > int'(amplitude_target_mv);
    end
  end
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the LED drive loop block.
// Assumes short update periods: 20 cycles slow, 4 fast.
`timescale 1ns/1ps

module tb;
  localparam int P = 20;
  logic        clk_sys = 1'b0;
  logic        resetn  = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, stuck = 1'b0;
  logic [13:0] adr  = '0;
  logic [3:0]  sel  = '0;
  logic [31:0] wdat = '0, rdat, q;
  logic        ack, above, sen, pin_o, oe_n, irq;
  logic [6:0]  sink, gain;
  logic [10:0] tgt_mv, ref_mv;
  int          mismatches = 0, n_tests = 0, cyc_n = 0, w, v;
  integer      seed = 32'h522c;
  int          gtab[8] = '{4, 6, 8, 12, 16, 24, 32, 48};
  int          rtab[4] = '{1150, 1200, 1250, 1300};

  lldc_top #(.SLOW_CYC(P), .FAST_CYC(4)) lldc_top_i (
    .clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .amplitude_above(above),
    .led_cathode_sink(sink), .sink_enable(sen), .buffer_gain_code(gain),
    .amplitude_target_mv(tgt_mv), .feedback_reference_mv(ref_mv),
    .interrupt_out_n(pin_o), .interrupt_oe_n(oe_n), .irq(irq));

  lldc_amp_model lldc_amp_model_i (
    .clk_sys(clk_sys), .resetn(resetn), .led_cathode_sink(sink),
    .sink_enable(sen), .amplitude_target_mv(tgt_mv), .stuck_high(stuck),
    .amplitude_above(above));

  // Clock and cycle count
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc_n <= cyc_n + 1;

  // ****************************************************
  // Bus, compare and closing tasks
  // ****************************************************
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t reg %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t pin %h want %h", $time, got, exp);
    end
  endtask

  // One classic cycle; master waits on ack under a bound
  task automatic wb(input logic [11:0] idx, input logic w_en,
                    input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    cyc <= 1'b1; stb <= 1'b1; we <= w_en; sel <= 4'hF;
    adr <= {idx, 2'b00}; wdat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      $display("CHECK FAILED %0t no bus answer", $time);
      report_and_stop();
    end else begin
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    end
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_sys);
  endtask

  // Closed loop run against the bench's own stepping model
  task automatic loop_run(input int m, input int h, input int k);
    int c0;
    wb(12'h887, 1'b1, 8'h40 | h[7:0]);
    wb(12'h886, 1'b1, 8'h80 | m[7:0]);
    c0 = cyc_n;
    w = m * 7 / 8;
    settle();
    chk_pin(sink, w);
    for (int i = 1; i <= k; i++) begin
      // Old code must stand just before the tick, new one just after
      while (cyc_n < c0 + i * P - 1) @(posedge clk_sys);
      chk_pin(sink, w);
      while (cyc_n < c0 + i * P + 1) @(posedge clk_sys);
      if (stuck || w * 20 > 500 + 100 * h) w = (w > 0) ? w - 1 : 0;
      else w = (w < m) ? w + 1 : m;
      chk_pin(sink, w);
      wb(12'h88F, 1'b0, 8'h00);
      chk_reg(q, {24'h0, 1'b1, w[6:0]});
    end
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    // Reset values, an unmapped place and a read-only place
    wb(12'h886, 1'b0, 0); chk_reg(q, 32'h00);
    wb(12'h887, 1'b0, 0); chk_reg(q, 32'h40);
    wb(12'h883, 1'b0, 0); chk_reg(q, 32'h00);
    wb(12'h884, 1'b1, 8'h5A);
    wb(12'h884, 1'b0, 0); chk_reg(q, 32'h00);
    wb(12'h88F, 1'b1, 8'hFF);
    wb(12'h88F, 1'b0, 0); chk_reg(q, 32'h00);
    // Every gain code
    for (int c = 0; c < 16; c++) begin
      wb(12'h883, 1'b1, c[7:0]);
      settle();
      chk_pin(gain, c[3] ? 64 : gtab[c[2:0]]);
      wb(12'h883, 1'b0, 0); chk_reg(q, c);
    end
    // Every reference code with random target levels
    for (int f = 0; f < 4; f++) begin
      v = $random(seed) & 7;
      wb(12'h887, 1'b1, {1'b0, f[1:0], 2'b00, v[2:0]});
      settle();
      chk_pin(tgt_mv, 500 + 100 * v);
      chk_pin(ref_mv, rtab[f]);
    end
    // Open loop with random codes, then all off
    for (int i = 0; i < 8; i++) begin
      v = $random(seed) & 8'h7F;
      wb(12'h886, 1'b1, v[7:0]);
      settle();
      chk_pin(sink, v);
      wb(12'h88F, 1'b0, 0); chk_reg(q, v);
    end
    wb(12'h886, 1'b1, 8'h00);
    settle();
    chk_pin(sen, 0);
    // Down steps toward a low target
    loop_run(40, 0, 6);
    wb(12'h886, 1'b1, 8'h28);
    // Up steps to the clamp, with the alarm raised
    wb(12'h889, 1'b1, 8'h00);
    loop_run(40, 7, 7);
    chk_pin({irq, oe_n}, 2'b01);
    wb(12'h889, 1'b0, 0); chk_reg(q, 32'h40);
    wb(12'h889, 1'b1, 8'h04);
    settle();
    chk_pin({irq, oe_n, oe_n ? 1'b1 : pin_o}, 3'b100);
    wb(12'h886, 1'b1, 8'h28);
    settle();
    chk_pin({irq, oe_n}, 2'b11);
    wb(12'h889, 1'b0, 0); chk_reg(q, 32'h44);
    wb(12'h889, 1'b0, 0); chk_reg(q, 32'h04);
    chk_pin({irq, oe_n}, 2'b01);
    // Faulty comparator drives the code to its floor
    stuck <= 1'b1;
    loop_run(3, 0, 4);
    report_and_stop();
  end
endmodule
